// ### core/psq_sequencer.sv
// power start-up sequencer, reset supervisor and hibernate control
// assumes an APB master on pclk and analog comparators on the inputs
`timescale 1ns/1ps
`default_nettype none
`include "psq_defines.svh"

// Contract
// (RL1) regulation target starts at 15V; 9V or 12V only once running
// (RL2) sense input picks high-side or low-side mode at start-up, latched
// (RL3) safe start at 11.4kHz until main rail passes undervoltage lockout
// (RL4) default 45kHz for at least 6ms before regulators turn on
// (RL5) software picks high-frequency or low-frequency switching mode
// (RL6) each frequency mode offers eight selectable settings
// (RL7) software programs target, mode, frequency and clamp at initialisation
// (RL8) software should disable the switcher when main rail fed directly
// (RL9) flash, io, mixed and core regulators turn on one after another
// (RL10) reset released only when four rails good and reset timer done
// (RL11) hibernate shuts down the switcher and every regulator
// (RL12) hibernate ends on wake timer, plus push button when enabled
// (RL13) wake field 3 bits: 125ms doubling to 8s, last code never
// (RL14) hibernate exit reruns start-up and fully resets the core
// (RL15) only persistent fault and reset-cause bits survive hibernate
// (RL16) any rail below good flags fault and holds core in reset
// (RL17) over-temperature fault resets the core, cannot be masked
// (RL18) fault bits survive core reset and stay readable afterwards
// (RL19) temperature warning is a maskable interrupt to the core
// (RL20) supply monitor selects one of seven sources
// (RL21) threshold reference selects one of four levels
// (RL22) clocks run only once supplies ready, before core leaves reset
module psq_sequencer #(
  parameter int unsigned DEF_CYC = `PSQ_DEF_FREQ_MIN_MS * `PSQ_CLK_KHZ,
  parameter int unsigned WAKE_BASE_CYC = `PSQ_WAKE_BASE_MS * `PSQ_CLK_KHZ,
  parameter int unsigned POR_BASE_CYC = `PSQ_POR_BASE_CYC,
  parameter int unsigned SEQ_STEP_CYC = `PSQ_SEQ_STEP_CYC
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator levels
  input wire logic current_sense_input_high,
  input wire logic main_rail_uvlo_ok,
  input wire logic system_5v_rail_good,
  input wire logic io_3v3_rail_good,
  input wire logic mixed_3v3_rail_good,
  input wire logic core_1v2_rail_good,
  input wire logic die_temp_warn,
  input wire logic die_temp_fault,
  input wire logic push_button,
  // analog controls
  output psq_pkg::psq_sw_s switching_supply_ctrl,
  output psq_pkg::psq_reg_en_s regulator_en,
  output logic [2:0] supply_monitor_output_sel,
  output logic [1:0] threshold_reference_sel,
  // core side
  output logic mcu_rst_n,
  output logic clk_avail,
  output logic temp_warn_irq
);

  localparam psq_pkg::psq_state_s ST_RST = '{
    state: psq_pkg::ST_SAFE,
    ctrl: `PSQ_CTRL_RST,
    fault: `PSQ_FLT_RST,
    sw: '{mode: psq_pkg::FM_SAFE, sense: psq_pkg::SENSE_HIGH_SIDE,
          en: 1'b1, target: `PSQ_VP_15V, default: '0},
    default: '0
  };

  psq_pkg::psq_state_s st_reg;
  psq_pkg::psq_state_s st_next;
  logic [`PSQ_IN_W-1:0] pins;
  logic all_good;
  logic acc;
  logic wr_done;
  logic wake_exp;
  logic wake_never;
  logic pb_evt;
  logic [31:0] por_lim;
  logic [31:0] wake_lim;
  logic [2:0] wake_sel;

  // pin levels gathered in sync order
  assign pins = {push_button, die_temp_fault, die_temp_warn,
                 core_1v2_rail_good, mixed_3v3_rail_good, io_3v3_rail_good,
                 system_5v_rail_good, main_rail_uvlo_ok,
                 current_sense_input_high};

  // outputs straight from state flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign switching_supply_ctrl = st_reg.sw;
  assign regulator_en = st_reg.regs;
  assign supply_monitor_output_sel = st_reg.ctrl[`PSQ_CTRL_MON_LSB +: 3];
  // (RL21) one of four threshold levels
  assign threshold_reference_sel = st_reg.ctrl[`PSQ_CTRL_THR_LSB +: 2];
  assign mcu_rst_n = st_reg.mcu_rst_n;
  assign clk_avail = st_reg.clk_avail;
  assign temp_warn_irq = st_reg.irq;

  // derived levels and timer limits
  assign all_good = &st_reg.filt[`PSQ_IN_CORE:`PSQ_IN_SYS];
  assign acc = psel & penable;
  assign wr_done = acc & st_reg.pready & pwrite & ~st_reg.pslverr;
  assign por_lim = 32'(POR_BASE_CYC) << st_reg.ctrl[`PSQ_CTRL_POR_LSB +: 2];
  assign wake_sel = st_reg.ctrl[`PSQ_CTRL_WAKE_LSB +: 3];
  // (RL13) doubling wake durations
  assign wake_lim = 32'(WAKE_BASE_CYC) << wake_sel;
  assign wake_never = (wake_sel == `PSQ_WAKE_NEVER);
  assign wake_exp = ~wake_never & (st_reg.cnt >= wake_lim - 32'h1);
  assign pb_evt = st_reg.filt[`PSQ_IN_PB] & ~st_reg.pb_prev;

  // next-state logic
  always_comb begin
    st_next = st_reg;
    // three-stage sync, change taken when stages two and three agree
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    st_next.filt = (st_reg.sync2 & st_reg.sync3)
                 | (st_reg.filt & (st_reg.sync2 ^ st_reg.sync3));
    st_next.pb_prev = st_reg.filt[`PSQ_IN_PB];

    // apb: one wait cycle, answer registered
    st_next.pready = acc & ~st_reg.pready;
    if (acc && !st_reg.pready) begin
      st_next.pslverr = 1'b0;
      unique case (paddr)
        `PSQ_OFF_CTRL: st_next.prdata = {11'h000, st_reg.ctrl};
        `PSQ_OFF_STATUS: st_next.prdata = {16'h0000,
            3'h0, st_reg.filt[`PSQ_IN_SENSE +: 8], st_reg.sw.sense,
            1'b0, st_reg.state};
        `PSQ_OFF_FAULT: st_next.prdata = {28'h0000000, st_reg.fault};
        `PSQ_OFF_IRQ: st_next.prdata = {30'h00000000, st_reg.irq,
            st_reg.irq_mask};
        default: begin
          st_next.prdata = 32'h00000000;
          st_next.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_done) begin
      unique case (paddr)
        `PSQ_OFF_CTRL: begin
          // (RL1) settings only accepted once running
          if (st_reg.state == psq_pkg::ST_RUN) begin
            st_next.ctrl = pwdata[`PSQ_CTRL_W-1:0];
            st_next.ctrl[`PSQ_CTRL_HIB] = 1'b0;
            if (pwdata[`PSQ_CTRL_VPT_LSB +: 2] == 2'h3) begin
              st_next.ctrl[`PSQ_CTRL_VPT_LSB +: 2] =
                st_reg.ctrl[`PSQ_CTRL_VPT_LSB +: 2];
            end
            // (RL20) seven monitor sources, eighth code ignored
            if (pwdata[`PSQ_CTRL_MON_LSB +: 3] == `PSQ_MON_BAD) begin
              st_next.ctrl[`PSQ_CTRL_MON_LSB +: 3] =
                st_reg.ctrl[`PSQ_CTRL_MON_LSB +: 3];
            end
          end
        end
        // (RL18) write one to clear, sets below win
        `PSQ_OFF_FAULT: st_next.fault = st_reg.fault & ~pwdata[3:0];
        // (RL19) warning mask
        `PSQ_OFF_IRQ: st_next.irq_mask = pwdata[0];
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end

    // (RL19) warning interrupt gated by mask
    st_next.irq = st_reg.filt[`PSQ_IN_WARN] & st_reg.irq_mask;

    // sequencer
    unique case (st_reg.state)
      psq_pkg::ST_SAFE: begin
        // (RL3) safe start-up frequency
        st_next.sw.en = 1'b1;
        st_next.sw.mode = psq_pkg::FM_SAFE;
        st_next.sw.target = `PSQ_VP_15V;
        // (RL2) sense mode tracked, frozen on leaving
        st_next.sw.sense = st_reg.filt[`PSQ_IN_SENSE] ?
          psq_pkg::SENSE_HIGH_SIDE : psq_pkg::SENSE_LOW_SIDE;
        if (st_reg.filt[`PSQ_IN_UVLO]) begin
          st_next.state = psq_pkg::ST_DEFAULT;
          st_next.sw.mode = psq_pkg::FM_DEFAULT;
          st_next.cnt = 32'h0;
        end
      end
      psq_pkg::ST_DEFAULT: begin
        // (RL4) hold default frequency the minimum time
        st_next.cnt = st_reg.cnt + 32'h1;
        if (st_reg.cnt == 32'(DEF_CYC - 1)) begin
          st_next.state = psq_pkg::ST_SYS;
          st_next.regs.sys = 1'b1;
          st_next.cnt = 32'h0;
        end
      end
      psq_pkg::ST_SYS: begin
        if (st_reg.filt[`PSQ_IN_SYS]) begin
          st_next.state = psq_pkg::ST_SEQ;
          st_next.idx = 2'h0;
          st_next.cnt = 32'h0;
        end
      end
      psq_pkg::ST_SEQ: begin
        // (RL9) regulators on one per step
        st_next.cnt = st_reg.cnt + 32'h1;
        if (st_reg.cnt == 32'(SEQ_STEP_CYC - 1)) begin
          st_next.regs.seq[st_reg.idx] = 1'b1;
          st_next.idx = st_reg.idx + 2'h1;
          st_next.cnt = 32'h0;
          if (st_reg.idx == 2'h3) begin
            st_next.state = psq_pkg::ST_POR;
          end
        end
      end
      psq_pkg::ST_POR: begin
        st_next.mcu_rst_n = 1'b0;
        // (RL22) clocks follow ready supplies
        st_next.clk_avail = all_good;
        // (RL10) timer runs only while rails good and die cool
        if (all_good && !st_reg.filt[`PSQ_IN_TFLT]) begin
          st_next.cnt = st_reg.cnt + 32'h1;
          if (st_reg.cnt >= por_lim - 32'h1) begin
            st_next.state = psq_pkg::ST_RUN;
            st_next.mcu_rst_n = 1'b1;
            st_next.cnt = 32'h0;
          end
        end else begin
          st_next.cnt = 32'h0;
        end
      end
      psq_pkg::ST_RUN: begin
        // (RL8) switcher off on request for direct supply
        st_next.sw.en = ~st_reg.ctrl[`PSQ_CTRL_SSDIS];
        // (RL5) software frequency mode and (RL6) setting
        st_next.sw.mode = st_reg.ctrl[`PSQ_CTRL_FMODE] ?
          psq_pkg::FM_HIGH : psq_pkg::FM_LOW;
        st_next.sw.sel = st_reg.ctrl[`PSQ_CTRL_FSEL_LSB +: 3];
        st_next.sw.target = st_reg.ctrl[`PSQ_CTRL_VPT_LSB +: 2];
        st_next.sw.clamp = st_reg.ctrl[`PSQ_CTRL_CLAMP];
        if (!all_good || st_reg.filt[`PSQ_IN_TFLT]) begin
          // (RL16) rail fault holds the core in reset
          if (!all_good) begin
            st_next.fault[`PSQ_FLT_RAIL] = 1'b1;
          end
          // (RL17) temperature fault, no mask
          if (st_reg.filt[`PSQ_IN_TFLT]) begin
            st_next.fault[`PSQ_FLT_TEMP] = 1'b1;
          end
          st_next.state = psq_pkg::ST_POR;
          st_next.mcu_rst_n = 1'b0;
          st_next.cnt = 32'h0;
        end else if (wr_done && paddr == `PSQ_OFF_CTRL &&
                     pwdata[`PSQ_CTRL_HIB]) begin
          // (RL11) everything off in hibernate
          st_next.state = psq_pkg::ST_HIB;
          st_next.sw.en = 1'b0;
          st_next.regs = '0;
          st_next.mcu_rst_n = 1'b0;
          st_next.clk_avail = 1'b0;
          st_next.cnt = 32'h0;
        end
      end
      psq_pkg::ST_HIB: begin
        if (!wake_exp && !wake_never) begin
          st_next.cnt = st_reg.cnt + 32'h1;
        end
        // (RL12) timer, then push button when enabled
        if (st_reg.ctrl[`PSQ_CTRL_PBEN] ? (pb_evt & (wake_exp | wake_never))
                                         : wake_exp) begin
          // (RL14) full start-up again, core held in reset
          st_next.state = psq_pkg::ST_SAFE;
          st_next.sw = ST_RST.sw;
          st_next.cnt = 32'h0;
          // (RL15) all but the persistent fault bits lost
          st_next.ctrl = `PSQ_CTRL_RST;
          st_next.irq_mask = 1'b0;
          st_next.fault[`PSQ_FLT_WAKE] = 1'b1;
          // synced levels restart, so a rail lost in hibernate is seen
          st_next.sync2 = '0;
          st_next.sync3 = '0;
          st_next.filt = '0;
          st_next.pb_prev = 1'b0;
        end
      end
      default: st_next.state = psq_pkg::ST_SAFE;
    endcase
  end

  // state register, frozen while ce low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  init_target_a: assert property ( // RL1
    st_reg.state inside {psq_pkg::ST_SAFE, psq_pkg::ST_DEFAULT,
                         psq_pkg::ST_SYS, psq_pkg::ST_SEQ}
    |-> st_reg.sw.target == `PSQ_VP_15V)
    else $error("target not 15V during start-up");
  sense_latch_a: assert property ( // RL2
    st_reg.state != psq_pkg::ST_SAFE && $past(st_reg.state) != psq_pkg::ST_SAFE
    |-> $stable(st_reg.sw.sense))
    else $error("sense mode changed after start-up");
  safe_freq_a: assert property ( // RL3
    st_reg.state == psq_pkg::ST_SAFE && !st_reg.filt[`PSQ_IN_UVLO]
    |=> st_reg.sw.mode == psq_pkg::FM_SAFE && st_reg.sw.en)
    else $error("left safe frequency before lockout cleared");
  default_hold_a: assert property ( // RL4
    $rose(st_reg.regs.sys) |-> $past(st_reg.state) == psq_pkg::ST_DEFAULT
    && $past(st_reg.cnt) == 32'(DEF_CYC - 1))
    else $error("regulators on before default interval");
  freq_mode_a: assert property ( // RL5
    st_reg.state == psq_pkg::ST_RUN ##1 st_reg.state == psq_pkg::ST_RUN
    |-> st_reg.sw.mode == (st_reg.ctrl[`PSQ_CTRL_FMODE] ? psq_pkg::FM_HIGH
        : psq_pkg::FM_LOW) || $changed(st_reg.ctrl))
    else $error("run frequency mode wrong");
  seq_order_a: assert property ( // RL9
    st_reg.regs.seq != 4'h0 |-> st_reg.regs.sys &&
    (st_reg.regs.seq & 4'(st_reg.regs.seq + 4'h1)) == 4'h0)
    else $error("regulators out of order");
  rst_release_a: assert property ( // RL10
    $rose(st_reg.mcu_rst_n) |-> $past(all_good)
    && !$past(st_reg.filt[`PSQ_IN_TFLT]) && st_reg.clk_avail)
    else $error("reset released with rail down");
  hib_off_a: assert property ( // RL11
    st_reg.state == psq_pkg::ST_HIB |-> !st_reg.sw.en
    && st_reg.regs == '0 && !st_reg.mcu_rst_n)
    else $error("supply left on in hibernate");
  wake_timer_a: assert property ( // RL12
    st_reg.state == psq_pkg::ST_HIB ##1 st_reg.state == psq_pkg::ST_SAFE
    |-> $past(wake_exp || wake_never))
    else $error("hibernate left before wake timer");
  hib_exit_a: assert property ( // RL14
    st_reg.state == psq_pkg::ST_HIB ##1 st_reg.state != psq_pkg::ST_HIB
    |-> st_reg.state == psq_pkg::ST_SAFE && st_reg.fault[`PSQ_FLT_WAKE]
    && !st_reg.mcu_rst_n)
    else $error("hibernate exit not a full restart");
  rail_fault_a: assert property ( // RL16
    st_reg.state == psq_pkg::ST_RUN && !all_good
    |=> !st_reg.mcu_rst_n && st_reg.fault[`PSQ_FLT_RAIL])
    else $error("rail fault not caught");
  temp_fault_a: assert property ( // RL17
    st_reg.state == psq_pkg::ST_RUN && st_reg.filt[`PSQ_IN_TFLT]
    |=> !st_reg.mcu_rst_n && st_reg.fault[`PSQ_FLT_TEMP])
    else $error("temperature fault not caught");
  warn_irq_a: assert property ( // RL19
    st_reg.filt[`PSQ_IN_WARN] && st_reg.irq_mask |=> st_reg.irq)
    else $error("warning interrupt missing");

  run_reached_c: cover property ($rose(st_reg.mcu_rst_n));
  hib_wake_c: cover property (
    st_reg.state == psq_pkg::ST_HIB ##1 st_reg.state == psq_pkg::ST_SAFE);
  rail_fault_c: cover property (
    st_reg.state == psq_pkg::ST_RUN ##1 st_reg.fault[`PSQ_FLT_RAIL]);
  temp_fault_c: cover property (
    st_reg.state == psq_pkg::ST_RUN ##1 st_reg.fault[`PSQ_FLT_TEMP]);

endmodule : psq_sequencer
`default_nettype wire

// ### shared/psq_defines.svh
// offsets, field positions, reset values and timing counts of the sequencer
// assumes inclusion by bare name from the package and the design file
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH

// clock rate and documented times
`define PSQ_CLK_KHZ 125000
`define PSQ_DEF_FREQ_MIN_MS 6
`define PSQ_WAKE_BASE_MS 125
`define PSQ_SEQ_STEP_CYC 16
`define PSQ_POR_BASE_CYC 1024

// register byte offsets
`define PSQ_OFF_CTRL 12'h000
`define PSQ_OFF_STATUS 12'h004
`define PSQ_OFF_FAULT 12'h008
`define PSQ_OFF_IRQ 12'h00c

// control register fields
`define PSQ_CTRL_W 21
`define PSQ_CTRL_VPT_LSB 0
`define PSQ_CTRL_SSDIS 2
`define PSQ_CTRL_FMODE 3
`define PSQ_CTRL_FSEL_LSB 4
`define PSQ_CTRL_CLAMP 7
`define PSQ_CTRL_MON_LSB 8
`define PSQ_CTRL_THR_LSB 11
`define PSQ_CTRL_POR_LSB 13
`define PSQ_CTRL_HIB 16
`define PSQ_CTRL_PBEN 17
`define PSQ_CTRL_WAKE_LSB 18
`define PSQ_CTRL_RST 21'h000000

// regulation target codes
`define PSQ_VP_15V 2'h0
`define PSQ_VP_12V 2'h1
`define PSQ_VP_9V 2'h2

// codes with special meaning
`define PSQ_WAKE_NEVER 3'h7
`define PSQ_MON_BAD 3'h7

// fault register bits and reset value
`define PSQ_FLT_POR 0
`define PSQ_FLT_RAIL 1
`define PSQ_FLT_TEMP 2
`define PSQ_FLT_WAKE 3
`define PSQ_FLT_RST 4'h1

// synchronised input positions
`define PSQ_IN_W 9
`define PSQ_IN_SENSE 0
`define PSQ_IN_UVLO 1
`define PSQ_IN_SYS 2
`define PSQ_IN_CORE 5
`define PSQ_IN_WARN 6
`define PSQ_IN_TFLT 7
`define PSQ_IN_PB 8

`endif

// ### shared/psq_pkg.sv
// types of the power sequencer and supervisor
// assumes psq_defines.svh on the include path
`include "psq_defines.svh"
package psq_pkg;

  typedef enum logic [2:0] {
    ST_SAFE, ST_DEFAULT, ST_SYS, ST_SEQ, ST_POR, ST_RUN, ST_HIB
  } psq_fsm_e;

  typedef enum logic [1:0] {FM_SAFE, FM_DEFAULT, FM_LOW, FM_HIGH} psq_fmode_e;

  typedef enum logic {SENSE_HIGH_SIDE, SENSE_LOW_SIDE} psq_sense_e;

  // command word to the switching supply controller
  typedef struct packed {
    logic en;
    psq_fmode_e mode;
    logic [2:0] sel;
    psq_sense_e sense;
    logic [1:0] target;
    logic clamp;
  } psq_sw_s;

  // regulator enables; seq holds flash, io, mixed, core from bit 0
  typedef struct packed {
    logic sys;
    logic [3:0] seq;
  } psq_reg_en_s;

  // whole state of the sequencer
  typedef struct packed {
    logic [`PSQ_IN_W-1:0] sync1;
    logic [`PSQ_IN_W-1:0] sync2;
    logic [`PSQ_IN_W-1:0] sync3;
    logic [`PSQ_IN_W-1:0] filt;
    logic pb_prev;
    psq_fsm_e state;
    logic [31:0] cnt;
    logic [1:0] idx;
    logic [`PSQ_CTRL_W-1:0] ctrl;
    logic [3:0] fault;
    logic irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    psq_sw_s sw;
    psq_reg_en_s regs;
    logic mcu_rst_n;
    logic clk_avail;
  } psq_state_s;

endpackage : psq_pkg

// ### dv/psq_plant.sv
// stand-in for the supply rails, the lockout comparator and the rail monitors
// assumes enables from the sequencer; each rail settles LAG cycles later
`timescale 1ns/1ps
`default_nettype none
module psq_plant #(
  parameter int LAG = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controls from the sequencer
  input wire psq_pkg::psq_sw_s sw,
  input wire psq_pkg::psq_reg_en_s ren,
  // external supply present, forced core rail drop
  input wire logic ext,
  input wire logic drop,
  // comparator levels
  output logic uvlo,
  output logic sys_g,
  output logic io_g,
  output logic mx_g,
  output logic core_g
);
  logic [4:0] tgt;
  logic [4:0] pipe [LAG];
  // each regulator rail only comes up while its parent rail is up; the main rail follows sw.en or ext
  assign tgt = {ren.seq[3] & sys_g & !drop, ren.seq[2] & sys_g,
                ren.seq[1] & sys_g, ren.sys & uvlo, sw.en | ext};
  // slow rise and fall of every rail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LAG; i++) pipe[i] <= 5'h00;
    end else begin
      pipe[0] <= tgt;
      for (int i = 1; i < LAG; i++) pipe[i] <= pipe[i-1];
    end
  end
  assign {core_g, mx_g, io_g, sys_g, uvlo} = pipe[LAG-1];
endmodule : psq_plant
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the power sequencer and supervisor
// assumes psq_plant in place of the rails; apb master is this bench
`timescale 1ns/1ps
`default_nettype none
`include "psq_defines.svh"
module tb;
  localparam int DEF = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sense = 1'b0, warn = 1'b0, tflt = 1'b0, pb = 1'b0;
  logic ext = 1'b0, drop = 1'b0, ce = 1'b1;
  logic uvlo, sys_g, io_g, mx_g, core_g, rst_n, clk_av, irq;
  psq_pkg::psq_sw_s sw;
  psq_pkg::psq_reg_en_s ren;
  psq_pkg::psq_fmode_e mode_q = psq_pkg::FM_SAFE;
  logic [2:0] mon;
  logic [1:0] thr;
  logic [3:0] seq_q = 4'h0;
  logic rst_q = 1'b0, sys_q = 1'b0, err;
  logic [31:0] rd, cv;
  int bad_count = 0, cmp_count = 0, cyc = 0, dcnt = 0;

  always #4 pclk = ~pclk;

  psq_sequencer #(.DEF_CYC(DEF), .WAKE_BASE_CYC(8), .POR_BASE_CYC(4),
    .SEQ_STEP_CYC(16)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_sense_input_high(sense), .main_rail_uvlo_ok(uvlo),
    .system_5v_rail_good(sys_g), .io_3v3_rail_good(io_g),
    .mixed_3v3_rail_good(mx_g), .core_1v2_rail_good(core_g),
    .die_temp_warn(warn), .die_temp_fault(tflt), .push_button(pb),
    .switching_supply_ctrl(sw), .regulator_en(ren),
    .supply_monitor_output_sel(mon), .threshold_reference_sel(thr),
    .mcu_rst_n(rst_n), .clk_avail(clk_av), .temp_warn_irq(irq));

  psq_plant #(.LAG(6)) plant_u (.pclk(pclk), .presetn(presetn), .sw(sw),
    .ren(ren), .ext(ext), .drop(drop), .uvlo(uvlo), .sys_g(sys_g),
    .io_g(io_g), .mx_g(mx_g), .core_g(core_g));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // wait a bounded time for the core reset level
  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (rst_n !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(rst_n, v);
  endtask : wait_rst

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask : end_test

  function automatic logic [31:0] ctl(input logic [1:0] vp,
      input logic ds, input logic fm, input logic [2:0] fs,
      input logic cl, input logic [2:0] mo, input logic [1:0] th,
      input logic hib, input logic pbe, input logic [2:0] wk);
    ctl = {11'h0, wk, pbe, hib, 3'h0, th, mo, cl, fs, fm, ds, vp};
  endfunction : ctl

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end

  // start-up order watch on every cycle
  always @(posedge pclk) begin
    mode_q <= sw.mode;
    sys_q <= ren.sys;
    seq_q <= ren.seq;
    rst_q <= rst_n;
    dcnt <= (sw.mode == psq_pkg::FM_DEFAULT) ? dcnt + 1 : 0;
    if (presetn) begin
      if (mode_q == psq_pkg::FM_SAFE && sw.mode != psq_pkg::FM_SAFE)
        chk(uvlo, 1'b1);
      if (ren.sys && !sys_q) chk(dcnt >= DEF, 1'b1);
      if (ren.seq != seq_q) chk(ren.seq & (ren.seq + 4'h1), 4'h0);
      if (rst_n && !rst_q)
        chk({sys_g, io_g, mx_g, core_g, clk_av}, 5'h1f);
    end
  end

  initial begin
    void'($urandom(32'h89cc9deb));
    sense = $urandom_range(0, 1);
    repeat (7) @(posedge pclk);
    chk({sw.en, sw.mode, sw.target}, {1'b1, psq_pkg::FM_SAFE, 2'h0});
    chk({ren, rst_n, clk_av, irq}, 8'h00);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PSQ_OFF_FAULT, 32'h0);
    chk(rd, 32'h1);
    wait_rst(1'b1, 3000);
    chk(sw.sense, sense ? psq_pkg::SENSE_HIGH_SIDE
                        : psq_pkg::SENSE_LOW_SIDE);
    chk(sw.target, `PSQ_VP_15V);
    sense <= ~sense;
    repeat (10) @(posedge pclk);
    chk(sw.sense, sense ? psq_pkg::SENSE_LOW_SIDE
                        : psq_pkg::SENSE_HIGH_SIDE);
    sense <= ~sense;
    apb(1'b0, `PSQ_OFF_STATUS, 32'h0);
    chk(rd[2:0], 3'h5);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    end_test("start");
    for (int i = 0; i < 6; i++) begin
      cv = ctl(2'(i % 3), 1'b0, 1'(i / 3), 3'($urandom_range(0, 7)),
               1'($urandom_range(0, 1)), 3'($urandom_range(0, 6)),
               2'($urandom_range(0, 3)), 1'b0, 1'b0, 3'h0);
      apb(1'b1, `PSQ_OFF_CTRL, cv);
      apb(1'b0, `PSQ_OFF_CTRL, 32'h0);
      chk(rd, cv);
      chk(sw.target, cv[1:0]);
      chk(sw.mode, cv[3] ? psq_pkg::FM_HIGH : psq_pkg::FM_LOW);
      chk({sw.clamp, sw.sel}, cv[7:4]);
      chk({thr, mon}, {cv[12:11], cv[10:8]});
    end
    apb(1'b1, `PSQ_OFF_CTRL, cv | 32'h703);
    chk({sw.target, mon}, {cv[1:0], cv[10:8]});
    ext <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b1, `PSQ_OFF_CTRL, cv | 32'h4);
    repeat (2) @(posedge pclk);
    chk({sw.en, rst_n}, 2'h1);
    // reset timer doubled for the fault tests
    apb(1'b1, `PSQ_OFF_CTRL, cv | 32'h2000);
    repeat (2) @(posedge pclk);
    chk(sw.en, 1'b1);
    ext <= 1'b0;
    end_test("config");
    warn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({irq, rst_n}, 2'h1);
    apb(1'b1, `PSQ_OFF_IRQ, 32'h1);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b0, `PSQ_OFF_IRQ, 32'h0);
    chk(rd, 32'h3);
    warn <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(irq, 1'b0);
    // frozen while the clock enable is low
    ce <= 1'b0;
    warn <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(irq, 1'b0);
    ce <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(irq, 1'b1);
    warn <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(irq, 1'b0);
    end_test("warning");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) drop <= 1'b1;
      else tflt <= 1'b1;
      wait_rst(1'b0, 20);
      drop <= 1'b0;
      tflt <= 1'b0;
      wait_rst(1'b1, 3000);
      apb(1'b0, `PSQ_OFF_FAULT, 32'h0);
      chk(rd[k+1], 1'b1);
      apb(1'b1, `PSQ_OFF_FAULT, 32'hf);
      apb(1'b0, `PSQ_OFF_FAULT, 32'h0);
      chk(rd, 32'h0);
    end
    end_test("faults");
    apb(1'b1, `PSQ_OFF_CTRL, ctl(2'h0, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0,
        2'h0, 1'b1, 1'b0, 3'($urandom_range(0, 1))));
    repeat (3) @(posedge pclk);
    chk({ren, sw.en, rst_n}, 7'h00);
    wait_rst(1'b1, 3000);
    apb(1'b0, `PSQ_OFF_FAULT, 32'h0);
    chk(rd[3], 1'b1);
    apb(1'b0, `PSQ_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `PSQ_OFF_CTRL, ctl(2'h0, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0,
        2'h0, 1'b1, 1'b1, `PSQ_WAKE_NEVER));
    repeat (300) @(posedge pclk);
    apb(1'b0, `PSQ_OFF_STATUS, 32'h0);
    chk({rd[2:0], rst_n}, 4'hc);
    pb <= 1'b1;
    repeat (10) @(posedge pclk);
    pb <= 1'b0;
    wait_rst(1'b1, 3000);
    end_test("hibernate");
    complete_run();
  end
endmodule : tb
`default_nettype wire
